// File: include/amdec_pkg.sv
// amplifier address decoder: shared field layout, codes and types
// assumes one 10 MHz clock, async active-low reset at both ends
package amdec_pkg;
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned KIND_POS  = 31;
  localparam int unsigned AMP_POS   = 0;
  localparam int unsigned AMP_W     = 5;
  localparam int unsigned SENS_POS  = 8;
  localparam int unsigned SENS_W    = 2;
  localparam int unsigned LINK_POS  = 12;
  localparam int unsigned LINK_W    = 2;
  localparam int unsigned RAFT_POS  = 16;
  localparam int unsigned RAFT_W    = 5;

  localparam logic [4:0] AMP_MAX    = 5'h0f;
  localparam logic [4:0] AMP_WILD   = 5'h1f;
  localparam logic [1:0] SENS_MAX   = 2'h2;
  localparam logic [1:0] SENS_WILD  = 2'h3;
  localparam logic [1:0] LINK_MAX   = 2'h2;
  localparam logic [1:0] LINK_WILD  = 2'h3;
  localparam logic [4:0] RAFT_MAX   = 5'h18;
  localparam logic [4:0] RAFT_WILD  = 5'h1f;
  localparam logic [31:0] RSVD_MASK = 32'h7fe0_cce0;

  localparam logic [31:0] ADDR_RST  = 32'h0000_0000;

  // software register map of the requester end
  localparam logic [3:0] REG_ADDR   = 4'h0;
  localparam logic [3:0] REG_REF    = 4'h1;
  localparam logic [3:0] REG_CTRL   = 4'h2;
  localparam logic [3:0] REG_RESULT = 4'h3;
  localparam logic [3:0] REG_STAT   = 4'h4;
  localparam logic [3:0] REG_CLR    = 4'h5;
  localparam logic [3:0] REG_IEN    = 4'h6;
  localparam int unsigned IRQ_W     = 3;
  localparam int unsigned EV_DONE   = 0;
  localparam int unsigned EV_ERR    = 1;
  localparam int unsigned EV_MATCH  = 2;

  typedef struct packed {
    logic       pixels;
    logic [4:0] amp;
    logic [1:0] sens;
    logic [1:0] link;
    logic [4:0] raft;
  } amdec_fields_t;

  function automatic amdec_fields_t amdec_split(input logic [31:0] a);
    amdec_fields_t f;
    f.pixels = a[KIND_POS];
    f.amp    = a[AMP_POS +: AMP_W];
    f.sens   = a[SENS_POS +: SENS_W];
    f.link   = a[LINK_POS +: LINK_W];
    f.raft   = a[RAFT_POS +: RAFT_W];
    return f;
  endfunction : amdec_split

  // wildcard on either side matches every valid value of the other
  function automatic logic amdec_fmatch5(input logic [4:0] a,
                                         input logic [4:0] b,
                                         input logic [4:0] wild);
    return (a == wild) || (b == wild) || (a == b);
  endfunction : amdec_fmatch5

  function automatic logic amdec_fmatch2(input logic [1:0] a,
                                         input logic [1:0] b,
                                         input logic [1:0] wild);
    return (a == wild) || (b == wild) || (a == b);
  endfunction : amdec_fmatch2
endpackage : amdec_pkg

// File: include/amdec_if.sv
// amplifier address decoder: link between requester and decoder
// assumes both ends share clk_sys and nrst
`timescale 1ns/100ps
interface amdec_if;
  logic        req;
  logic [31:0] addr;
  logic [31:0] ref_addr;
  logic        ack;
  logic        err;
  logic        rsvd_err;
  logic        match;
  logic        pixels;
  logic        wild;
  logic [11:0] amp_index;

  modport dec (input req, addr, ref_addr,
               output ack, err, rsvd_err, match, pixels, wild, amp_index);
  modport req_end (output req, addr, ref_addr,
                   input ack, err, rsvd_err, match, pixels, wild,
                   amp_index);
endinterface : amdec_if

// File: hw/amdec_decoder.sv
// amplifier address decoder: device end, validates and matches addresses
// assumes requests come from logic on clk_sys, one per cycle at most
//
// Behaviour
// - one 32-bit word carries every field
// - kind flag: 0 metadata, 1 pixel data
// - amp 0..15 real, 16..30 bad, 31 wildcard
// - sensor 0..2 real, 3 wildcard
// - link 0..2 real, 3 wildcard
// - raft 0..24 real, 25..30 bad, 31 wildcard
// - resolve amp, sensor, link, raft hierarchically
// - nothing finer than one amplifier
// - same layout for any array size
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
module amdec_decoder (
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  amdec_if.dec        lnk
);
  import amdec_pkg::*;

  // nesting counts of a full array; the index stays 12 bits wide
  localparam logic [11:0] AMPS_PER_SENS = 12'h010;
  localparam logic [11:0] SENS_PER_LINK = 12'h003;
  localparam logic [11:0] LINK_PER_RAFT = 12'h003;
  localparam logic [11:0] RAFT_COUNT    = 12'h019;
  // index code for a word that names no single amplifier
  localparam logic [11:0] IDX_NONE      = 12'hfff;
  // every bit that some field owns
  localparam logic [31:0] USED_MASK     = (32'h0000_0001 << KIND_POS)
                                        | (32'(AMP_WILD) << AMP_POS)
                                        | (32'(SENS_WILD) << SENS_POS)
                                        | (32'(LINK_WILD) << LINK_POS)
                                        | (32'(RAFT_WILD) << RAFT_POS);
  localparam int unsigned AMP_TOTAL     = int'(RAFT_COUNT)
                                        * int'(LINK_PER_RAFT)
                                        * int'(SENS_PER_LINK)
                                        * int'(AMPS_PER_SENS);

  // the decoding below is written for these widths only
  if (ADDR_W != 32) begin : g_bad_word
    $error("address word must be 32 bits wide");
  end
  if (AMP_W != 5 || RAFT_W != 5) begin : g_bad_wide
    $error("amplifier and raft fields must be 5 bits wide");
  end
  if (SENS_W != 2 || LINK_W != 2) begin : g_bad_narrow
    $error("sensor and link fields must be 2 bits wide");
  end
  // the index uses amp[3:0], so one sensor holds sixteen amplifiers
  if (AMPS_PER_SENS != 12'(AMP_MAX) + 12'h001) begin : g_bad_amps
    $error("amplifier count per sensor does not fit the index");
  end
  // reserved bits and field bits must tile the word exactly
  if ((USED_MASK & RSVD_MASK) != 32'h0000_0000) begin : g_bad_overlap
    $error("reserved mask overlaps a field");
  end
  if ((USED_MASK | RSVD_MASK) != 32'hffff_ffff) begin : g_bad_gap
    $error("reserved mask leaves a bit unowned");
  end
  // the flat index must never reach the no-amplifier code
  if (AMP_TOTAL >= int'(IDX_NONE)) begin : g_bad_index
    $error("flat amplifier index overflows its code space");
  end

  // a code between the last real value and the wildcard
  function automatic logic amdec_hole(input logic [4:0] code,
                                      input logic [4:0] top,
                                      input logic [4:0] wild);
    return (code > top) && (code != wild);
  endfunction : amdec_hole

  // true when a word carries a hole code in amp or raft
  function automatic logic amdec_bad(input amdec_fields_t a);
    return amdec_hole(a.amp, AMP_MAX, AMP_WILD)
        || amdec_hole(a.raft, RAFT_MAX, RAFT_WILD);
  endfunction : amdec_bad

  function automatic logic amdec_any_wild(input amdec_fields_t a);
    return (a.amp == AMP_WILD) || (a.sens == SENS_WILD)
        || (a.link == LINK_WILD) || (a.raft == RAFT_WILD);
  endfunction : amdec_any_wild

  // flat amplifier number: raft, then link, then sensor, then amp
  function automatic logic [11:0] amdec_flat(input amdec_fields_t a);
    logic [11:0] n;
    n = 12'(a.raft) * LINK_PER_RAFT + 12'(a.link);
    n = n * SENS_PER_LINK + 12'(a.sens);
    n = n * AMPS_PER_SENS + 12'(a.amp[3:0]);
    return n;
  endfunction : amdec_flat

  amdec_fields_t f;
  amdec_fields_t r;
  logic          f_bad;
  logic          r_bad;
  logic          bad_d;
  logic          rsvd_d;
  logic          wild_d;
  logic          kind_eq;
  logic          fields_eq;
  logic          match_d;
  logic [11:0]   idx_d;

  always_comb begin
    f = amdec_split(lnk.addr);
    r = amdec_split(lnk.ref_addr);
  end

  // a hole code in either word spoils the whole lookup
  always_comb begin
    f_bad = amdec_bad(f);
    r_bad = amdec_bad(r);
    bad_d = f_bad || r_bad;
  end

  // reserved bits only matter in the word under test
  always_comb begin
    rsvd_d = |(lnk.addr & RSVD_MASK);
  end

  always_comb begin
    wild_d = amdec_any_wild(f);
  end

  // kind flag must agree exactly; no wildcard exists for it
  always_comb begin
    kind_eq   = (f.pixels == r.pixels);
    fields_eq = amdec_fmatch5(f.amp, r.amp, AMP_WILD)
             && amdec_fmatch2(f.sens, r.sens, SENS_WILD)
             && amdec_fmatch2(f.link, r.link, LINK_WILD)
             && amdec_fmatch5(f.raft, r.raft, RAFT_WILD);
    match_d   = !bad_d && kind_eq && fields_eq;
  end

  // wildcards and bad codes name no single amplifier
  always_comb begin
    idx_d = amdec_flat(f);
    if (wild_d || bad_d) begin
      idx_d = IDX_NONE;
    end
  end

  // one answer pulse per request, one cycle later
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lnk.ack <= 1'b0;
    end else begin
      lnk.ack <= lnk.req;
    end
  end

  // results hold until the next request, so a slow reader still sees them
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lnk.err <= 1'b0;
    end else if (lnk.req) begin
      lnk.err <= bad_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lnk.rsvd_err <= 1'b0;
    end else if (lnk.req) begin
      lnk.rsvd_err <= rsvd_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lnk.match <= 1'b0;
    end else if (lnk.req) begin
      lnk.match <= match_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lnk.pixels <= 1'b0;
    end else if (lnk.req) begin
      lnk.pixels <= f.pixels;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lnk.wild <= 1'b0;
    end else if (lnk.req) begin
      lnk.wild <= wild_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lnk.amp_index <= 12'h000;
    end else if (lnk.req) begin
      lnk.amp_index <= idx_d;
    end
  end
endmodule : amdec_decoder

// File: hw/amdec_requester.sv
// amplifier address decoder: requester end, software-driven via registers
// assumes a plain register port on clk_sys, read data one cycle later
`timescale 1ns/100ps
module amdec_requester (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  amdec_if.req_end         lnk
);
  import amdec_pkg::*;

  logic [31:0]      addr_q;
  logic [31:0]      ref_q;
  logic             req_q;
  logic [31:0]      result_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] ien_q;
  logic [IRQ_W-1:0] ev_d;
  logic [IRQ_W-1:0] stat_d;
  logic [IRQ_W-1:0] ien_d;

  assign lnk.addr     = addr_q;
  assign lnk.ref_addr = ref_q;
  assign lnk.req      = req_q;

  // addresses are frozen while a lookup is in flight
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_q <= ADDR_RST;
      ref_q  <= ADDR_RST;
    end else if (reg_wr && !req_q) begin
      if (reg_addr == REG_ADDR) addr_q <= reg_wdata;
      if (reg_addr == REG_REF)  ref_q  <= reg_wdata;
    end
  end

  // writing bit 0 of the control register starts one lookup
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= reg_wr && (reg_addr == REG_CTRL) && reg_wdata[0] && !req_q;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      result_q <= 32'h0000_0000;
    end else if (lnk.ack) begin
      result_q <= {lnk.amp_index, 14'h0000, lnk.wild, lnk.pixels,
                   lnk.rsvd_err, lnk.match, lnk.err, 1'b1};
    end
  end

  always_comb begin
    ev_d = '0;
    ev_d[EV_DONE]  = lnk.ack;
    ev_d[EV_ERR]   = lnk.ack && (lnk.err || lnk.rsvd_err);
    ev_d[EV_MATCH] = lnk.ack && lnk.match;
  end

  // set wins over a clear in the same cycle
  always_comb begin
    stat_d = stat_q | ev_d;
    if (reg_wr && reg_addr == REG_CLR) begin
      stat_d = (stat_q & ~reg_wdata[IRQ_W-1:0]) | ev_d;
    end
  end

  always_comb begin
    ien_d = ien_q;
    if (reg_wr && reg_addr == REG_IEN) begin
      ien_d = reg_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ien_q <= '0;
    end else begin
      ien_q <= ien_d;
    end
  end

  // built from next state so irq drops in the same cycle as the clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_d & ien_d);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_ADDR:   reg_rdata <= addr_q;
        REG_REF:    reg_rdata <= ref_q;
        REG_CTRL:   reg_rdata <= {31'h0000_0000, req_q};
        REG_RESULT: reg_rdata <= result_q;
        REG_STAT:   reg_rdata <= {29'h0000_0000, stat_q};
        REG_IEN:    reg_rdata <= {29'h0000_0000, ien_q};
        default:    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule : amdec_requester

// File: tb/amdec_props.sv
// amplifier address decoder: assertions on the link signals
// assumes amdec_if signals, clk_sys and async active-low nrst
`timescale 1ns/100ps
module amdec_props
  import amdec_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        req,
  input wire logic [31:0] addr,
  input wire logic [31:0] ref_addr,
  input wire logic        ack,
  input wire logic        err,
  input wire logic        rsvd_err,
  input wire logic        match,
  input wire logic        pixels,
  input wire logic        wild,
  input wire logic [11:0] amp_index
);
  logic [11:0] idx_c;
  // widened first: a 5-bit raft times three would wrap
  assign idx_c = ((12'(addr[20:16]) * 12'h3 + 12'(addr[13:12])) * 12'h3
                 + 12'(addr[9:8])) * 12'h10 + 12'(addr[3:0]);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ack_kind_a: assert property (
    req |=> ack && pixels == $past(addr[31]))
    else $error("ack or kind flag wrong");
  amp_bad_a: assert property (
    req && (addr[4:0] inside {[5'h10:5'h1e]}
    || ref_addr[4:0] inside {[5'h10:5'h1e]}) |=> err)
    else $error("bad amplifier code not flagged");
  raft_bad_a: assert property (
    req && addr[20:16] inside {[5'h19:5'h1e]} |=> err)
    else $error("bad raft code not flagged");
  wild_code_a: assert property (
    req && (addr[9:8] == SENS_WILD || addr[13:12] == LINK_WILD) |=> wild)
    else $error("wildcard not reported");
  rsvd_bits_a: assert property (
    req && (addr & RSVD_MASK) != 32'h0 |=> rsvd_err)
    else $error("reserved bits not flagged");
  err_nomatch_a: assert property (
    ack && err |-> !match)
    else $error("match despite error");
  wild_index_a: assert property (
    ack && (wild || err) |-> amp_index == 12'hfff)
    else $error("index not blank");
  amp_index_a: assert property (
    req |=> err || wild || amp_index == $past(idx_c))
    else $error("amplifier index wrong");
  cover property (ack && match);
  cover property (ack && err);
  cover property (ack && wild && match);
endmodule : amdec_props

// File: tb/tb.sv
// amplifier address decoder: bench driving the requester registers
// assumes decoder and requester joined by one amdec_if
`timescale 1ns/100ps
module tb;
  import amdec_pkg::*;
  logic        clk_sys;
  logic        nrst;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [31:0] v;
  logic [31:0] e;
  int          n_fail;
  int          n_compared;
  // {address, reference}
  logic [63:0] cases [8] = '{64'h8018_220f_8018_220f,
    64'h0000_0010_0000_0000, 64'h0019_0000_0000_0000, 64'h8003_111f_8003_1103,
    64'h0000_0040_8000_0000, 64'h0002_3300_0002_0300, 64'h001f_0000_0000_001e,
    64'h8001_0000_8002_0000};
  amdec_if lnk ();
  amdec_decoder amdec_decoder_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk));
  amdec_requester amdec_requester_inst (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .lnk(lnk));
  amdec_props amdec_props_inst (.clk_sys(clk_sys), .nrst(nrst),
    .req(lnk.req), .addr(lnk.addr), .ref_addr(lnk.ref_addr), .ack(lnk.ack),
    .err(lnk.err), .rsvd_err(lnk.rsvd_err), .match(lnk.match),
    .pixels(lnk.pixels), .wild(lnk.wild), .amp_index(lnk.amp_index));
  // one register cycle; read data lands in v
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : acc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // wildcard codes are all ones in their field, so masks serve both tests
  function automatic logic [31:0] exp_res(input logic [31:0] a, r);
    logic [31:0] f [4] = '{32'h1f, 32'h300, 32'h3000, 32'h1f_0000};
    logic er;
    logic w;
    logic m;
    er = a[4:0] inside {[5'h10:5'h1e]} || a[20:16] inside {[5'h19:5'h1e]}
      || r[4:0] inside {[5'h10:5'h1e]} || r[20:16] inside {[5'h19:5'h1e]};
    w = 1'b0;
    m = !er && a[31] == r[31];
    foreach (f[j]) begin
      w |= (a & f[j]) == f[j];
      m &= (a & f[j]) == (r & f[j]) || (a & f[j]) == f[j]
        || (r & f[j]) == f[j];
    end
    return {(er || w) ? 12'hfff : ((12'(a[20:16]) * 12'h3 + 12'(a[13:12]))
      * 12'h3 + 12'(a[9:8])) * 12'h10 + 12'(a[3:0]), 14'h0, w, a[31],
      (a & RSVD_MASK) != 32'h0, m, er, 1'b1};
  endfunction : exp_res
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk_sys);
    chk(irq, 1'b0);
    nrst <= 1'b1;
    acc(1'b1, REG_IEN, 32'h4);
    acc(1'b0, 4'hf, 32'h0);
    chk(v, 32'h0);
    foreach (cases[i]) begin
      acc(1'b1, REG_ADDR, cases[i][63:32]);
      acc(1'b1, REG_REF, cases[i][31:0]);
      acc(1'b1, REG_CTRL, 32'h1);
      // lands while busy, so the word under test must survive it
      acc(1'b1, REG_ADDR, ~cases[i][63:32]);
      v = 32'h0;
      for (int k = 0; k < 8 && v[0] !== 1'b1; k++) begin
        acc(1'b0, REG_STAT, 32'h0);
      end
      if (v[0] !== 1'b1) begin
        n_fail++;
        $display("unexpected at %0t: no done", $time);
        break;
      end
      e = exp_res(cases[i][63:32], cases[i][31:0]);
      chk(v[2:0], {e[2], e[1] | e[3], 1'b1});
      chk(irq, e[2]);
      acc(1'b0, REG_RESULT, 32'h0);
      chk(v, e);
      acc(1'b0, REG_ADDR, 32'h0);
      chk(v, cases[i][63:32]);
      acc(1'b1, REG_CLR, 32'h7);
      $display("case %0d done", i);
    end
    finish_test();
  end
endmodule : tb
